// ==== rtl/dscg_consts.vh ====
/*
  Constants of the clock generator: register byte addresses and indices,
  field positions, reset values and phase counts.
  Assumes inclusion by bare name from the design files of this block.
*/
`ifndef DSCG_CONSTS_VH
`define DSCG_CONSTS_VH

`define DSCG_ADDR_W 12
`define DSCG_CKSPD_IDX 12'h08F
`define DSCG_CKSPD_ADDR 12'h23C
`define DSCG_AUX_ADDR 12'h240
`define DSCG_STAT_ADDR 12'h244

`define DSCG_SEL_BIT 0
`define DSCG_ALE_OFF_BIT 0
`define DSCG_CKSPD_RESET 1'b0
`define DSCG_AUX_RESET 1'b0

`define DSCG_ST_MODE 0
`define DSCG_ST_CRST 1
`define DSCG_ST_XDAT 2
`define DSCG_ST_PH_LO 3
`define DSCG_ST_PH_HI 5
`define DSCG_ST_DIV 6
`define DSCG_ST_FEXT 7

`define DSCG_PH_LAST 3'h5
`define DSCG_PH_FIRST 3'h0
`define DSCG_ALE_PH_A 3'h0
`define DSCG_ALE_PH_B 3'h3
`define DSCG_FETCH_PH_A 3'h1
`define DSCG_FETCH_PH_B 3'h4

`define DSCG_RST_MC 2'h2

`endif

// ==== rtl/dscg_phase.v ====
/*
  Divide-by-two stage and six-state phase generator of the core clock.
  Assumes osc_rise is a one-cycle pulse per oscillator period and that
  double_speed only changes on a half_rise pulse.
*/
`timescale 1ns/100ps
`include "dscg_consts.vh"

module dscg_phase (
  input wire clk,
  input wire reset,
  input wire osc_rise,
  input wire double_speed,
  output wire half_rise,
  output wire core_tick,
  output wire cycle_end,
  output wire div_state,
  output wire [2:0] phase
);

  reg div_reg;
  reg [2:0] phase_reg;
  reg [2:0] phase_next;

  // Divider toggles once per oscillator period
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      div_reg <= 1'b0;
    end else if (osc_rise) begin
      div_reg <= ~div_reg;
    end
  end

  assign half_rise = osc_rise & ~div_reg;
  // Standard mode ticks on the divided clock, double speed bypasses it
  assign core_tick = double_speed ? osc_rise : half_rise;

  // Six phases per machine cycle: 12 or 6 oscillator periods
  always @* begin
    phase_next = phase_reg;
    if (core_tick) begin
      if (phase_reg == `DSCG_PH_LAST) begin
        phase_next = `DSCG_PH_FIRST;
      end else begin
        phase_next = phase_reg + 3'h1;
      end
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      phase_reg <= `DSCG_PH_FIRST;
    end else begin
      phase_reg <= phase_next;
    end
  end

  assign cycle_end = core_tick & (phase_reg == `DSCG_PH_LAST);
  assign div_state = div_reg;
  assign phase = phase_reg;

endmodule

// ==== rtl/dscg_top.v ====
/*
  Clock generator of the 8-bit core: standard / double-speed selection,
  glitch-free mode switch, reset pin qualification, and pacing of the
  address latch and program fetch strobes, with an APB register slave.
  Assumes oscillator_input, reset_pin, fetch_external and data_access are
  synchronous to clk, and that clk runs well above the oscillator rate.
*/
// Chosen here: register access over APB.
// Notes on behaviour
// - Reset pin high at two consecutive machine cycle boundaries resets the core.
// - Address latch strobe pulses at osc/6 in standard mode and osc/3 at double speed.
// - Each external data memory cycle drops exactly one address latch pulse.
// - With auxiliary control bit 0 set, no address latch pulse on internal fetches except in data cycles.
// - External fetch gives two fetch strobes per cycle, both dropped in data cycles.
// - Fetch strobe stays inactive while fetching from internal program memory.
// - Double-speed mode completes a machine cycle in 6 oscillator periods.
// - Standard mode divides the oscillator by two before the phase generator.
// - The select bit moves the core between 12 and 6 periods per cycle.
// - Core and peripherals share the same tick, so they speed up together.
// - A select change only takes effect on a rising edge of the halved clock.
// - Reset leaves standard mode; setting the select bit gives double speed.
// - Upper seven bits of the speed register are reserved and never written.
// - Speed register resets with the select bit clear; no bit addressing.
`timescale 1ns/100ps
`include "dscg_consts.vh"

module dscg_top (
  input wire clk,
  input wire reset,
  input wire oscillator_input,
  input wire reset_pin,
  input wire fetch_external,
  input wire data_access,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output wire core_tick,
  output wire periph_tick,
  output wire machine_cycle_end,
  output wire core_reset,
  output wire double_speed_active,
  output wire address_latch_strobe,
  output wire program_fetch_strobe_n
);

  // Address match shared by read and write decoding
  function addr_is;
    input [11:0] addr;
    input [11:0] target;
    begin
      addr_is = (addr == target);
    end
  endfunction

  // True for any mapped register
  function addr_mapped;
    input [11:0] addr;
    begin
      addr_mapped = addr_is(addr, `DSCG_CKSPD_ADDR) |
                    addr_is(addr, `DSCG_AUX_ADDR) |
                    addr_is(addr, `DSCG_STAT_ADDR);
    end
  endfunction

  reg osc_prev_reg;
  reg select_reg;
  reg mode_reg;
  reg aux_ale_off_reg;
  reg [1:0] rst_cnt_reg;
  reg [1:0] rst_cnt_next;
  reg core_reset_reg;
  reg xdata_cycle_reg;
  reg fetch_ext_reg;
  reg ale_reg;
  reg ale_next;
  reg fetch_n_reg;
  reg fetch_n_next;
  reg [31:0] prdata_reg;
  reg [31:0] rdata_next;
  reg pslverr_reg;

  wire osc_rise;
  wire half_rise;
  wire tick;
  wire cycle_end;
  wire div_state;
  wire [2:0] phase;
  wire apb_setup;
  wire apb_write;
  wire wr_ckspd;
  wire wr_aux;
  wire [7:0] status_byte;

  // Input taken as synchronous; edge found against last sample
  assign osc_rise = oscillator_input & ~osc_prev_reg;

  // Starts high so an input already high at release is not a false edge
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      osc_prev_reg <= 1'b1;
    end else begin
      osc_prev_reg <= oscillator_input;
    end
  end

  dscg_phase u_phase (
    .clk(clk),
    .reset(reset),
    .osc_rise(osc_rise),
    .double_speed(mode_reg),
    .half_rise(half_rise),
    .core_tick(tick),
    .cycle_end(cycle_end),
    .div_state(div_state),
    .phase(phase)
  );

  // APB decode; zero wait states, data prepared in the setup cycle
  assign apb_setup = psel & ~penable;
  assign apb_write = psel & penable & pwrite;
  assign wr_ckspd = apb_write & addr_is(paddr, `DSCG_CKSPD_ADDR);
  assign wr_aux = apb_write & addr_is(paddr, `DSCG_AUX_ADDR);

  // Software select bit; only bit 0 is stored, reserved writes dropped
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      select_reg <= `DSCG_CKSPD_RESET;
    end else if (core_reset_reg) begin
      select_reg <= `DSCG_CKSPD_RESET;
    end else if (wr_ckspd) begin
      select_reg <= pwdata[`DSCG_SEL_BIT];
    end
  end

  // Effective mode follows the select bit only on a halved-clock rise,
  // so a phase never gets a truncated tick at the switch
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      mode_reg <= `DSCG_CKSPD_RESET;
    end else if (half_rise) begin
      mode_reg <= select_reg;
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      aux_ale_off_reg <= `DSCG_AUX_RESET;
    end else if (core_reset_reg) begin
      aux_ale_off_reg <= `DSCG_AUX_RESET;
    end else if (wr_aux) begin
      aux_ale_off_reg <= pwdata[`DSCG_ALE_OFF_BIT];
    end
  end

  // Reset pin is sampled once per machine cycle; needs a running
  // oscillator, since without ticks no boundary ever comes
  always @* begin
    rst_cnt_next = rst_cnt_reg;
    if (cycle_end) begin
      if (!reset_pin) begin
        rst_cnt_next = 2'h0;
      end else if (rst_cnt_reg != `DSCG_RST_MC) begin
        rst_cnt_next = rst_cnt_reg + 2'h1;
      end
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      rst_cnt_reg <= 2'h0;
      core_reset_reg <= 1'b0;
    end else begin
      rst_cnt_reg <= rst_cnt_next;
      core_reset_reg <= (rst_cnt_next == `DSCG_RST_MC);
    end
  end

  // Cycle kind is fixed at the boundary for the whole next cycle
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      xdata_cycle_reg <= 1'b0;
      fetch_ext_reg <= 1'b0;
    end else if (cycle_end) begin
      xdata_cycle_reg <= data_access;
      fetch_ext_reg <= fetch_external;
    end
  end

  // Address latch: two phases per cycle, second one dropped in data cycles, both dropped with the aux bit on internal code outside data cycles
  always @* begin
    ale_next = 1'b0;
    if (!core_reset_reg) begin
      if (phase == `DSCG_ALE_PH_A) begin
        ale_next = 1'b1;
      end else if (phase == `DSCG_ALE_PH_B) begin
        ale_next = ~xdata_cycle_reg;
      end
      if (aux_ale_off_reg && !fetch_ext_reg && !xdata_cycle_reg) begin
        ale_next = 1'b0;
      end
    end
  end

  // Fetch strobe, active low: two per cycle on external code only, none in data cycles
  always @* begin
    fetch_n_next = 1'b1;
    if (!core_reset_reg && fetch_ext_reg && !xdata_cycle_reg) begin
      case (phase)
        `DSCG_FETCH_PH_A: begin
          fetch_n_next = 1'b0;
        end
        `DSCG_FETCH_PH_B: begin
          fetch_n_next = 1'b0;
        end
        default: begin
          fetch_n_next = 1'b1;
        end
      endcase
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      ale_reg <= 1'b0;
      fetch_n_reg <= 1'b1;
    end else begin
      ale_reg <= ale_next;
      fetch_n_reg <= fetch_n_next;
    end
  end

  assign status_byte = {fetch_ext_reg, div_state, phase,
                        xdata_cycle_reg, core_reset_reg, mode_reg};

  // Reserved bits read as zero rather than indeterminate
  always @* begin
    rdata_next = 32'h00000000;
    if (addr_is(paddr, `DSCG_CKSPD_ADDR)) begin
      rdata_next[`DSCG_SEL_BIT] = select_reg;
    end else if (addr_is(paddr, `DSCG_AUX_ADDR)) begin
      rdata_next[`DSCG_ALE_OFF_BIT] = aux_ale_off_reg;
    end else if (addr_is(paddr, `DSCG_STAT_ADDR)) begin
      rdata_next[7:0] = status_byte;
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      prdata_reg <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end else if (apb_setup) begin
      prdata_reg <= pwrite ? 32'h00000000 : rdata_next;
      pslverr_reg <= ~addr_mapped(paddr);
    end
  end

  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = pslverr_reg & psel & penable;

  // One shared tick for core and peripherals
  assign core_tick = tick;
  assign periph_tick = tick;
  assign machine_cycle_end = cycle_end;
  assign core_reset = core_reset_reg;
  assign double_speed_active = mode_reg;
  assign address_latch_strobe = ale_reg;
  assign program_fetch_strobe_n = fetch_n_reg;

endmodule

// ==== verif/dscg_osc_model.sv ====
/*
  Far-side oscillator: a free-running square wave of P clk periods.
  Assumes P is even and at least two.
*/
`timescale 1ns/100ps
module dscg_osc_model #(parameter int P = 4) (
  input wire clk,
  output logic osc
);
  int c = 0;
  initial osc = 1'b0;
  // Runs through reset, as a crystal would
  always @(posedge clk) begin
    c <= (c >= P - 1) ? 0 : c + 1;
    osc <= (c < P / 2);
  end
endmodule

// ==== verif/dscg_assertions.sv ====
/*
  Port checker of the clock generator, bound into the top module.
  Assumes a steady oscillator of P clk periods.
*/
`timescale 1ns/100ps
module dscg_chk #(parameter int P = 4) (
  input wire clk,
  input wire reset,
  input wire reset_pin,
  input wire fetch_external,
  input wire data_access,
  input wire core_tick,
  input wire periph_tick,
  input wire machine_cycle_end,
  input wire core_reset,
  input wire double_speed_active,
  input wire address_latch_strobe,
  input wire program_fetch_strobe_n
);
  int gap, tk;
  logic seen_t, seen_m, fq, dq;
  logic [1:0] rpc;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence rp_twice;
    rpc == 2'h2;
  endsequence
  // First tick after reset and first cycle after any reset have no reference
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      gap <= 1; tk <= 1; seen_t <= 1'b0; seen_m <= 1'b0;
      fq <= 1'b0; dq <= 1'b0; rpc <= 2'h0;
    end else begin
      gap <= core_tick ? 1 : gap + 1;
      if (core_tick) seen_t <= 1'b1;
      if (machine_cycle_end) begin
        tk <= 1; seen_m <= !core_reset; fq <= fetch_external; dq <= data_access;
        rpc <= reset_pin ? ((rpc == 2'h2) ? 2'h2 : rpc + 2'h1) : 2'h0;
      end else if (core_tick) tk <= tk + 1;
      if (core_reset) seen_m <= 1'b0;
    end
  end
  tick_same_a: assert property (core_tick == periph_tick)
    else $error("peripheral tick differs from core tick");
  gap_std_a: assert property (core_tick && seen_t && !double_speed_active |-> gap == 2*P)
    else $error("standard tick spacing wrong");
  gap_dbl_a: assert property (core_tick && seen_t && double_speed_active |-> gap == P)
    else $error("double-speed tick spacing wrong");
  mce_six_a: assert property (machine_cycle_end && seen_m |-> tk == 6)
    else $error("machine cycle not six phases");
  // Strobe is registered from the phase, so it rises two edges after the tick
  ale_tick_a: assert property ($rose(address_latch_strobe) && seen_t |->
    $past(core_tick, 2))
    else $error("latch strobe not on a phase step");
  fetch_cond_a: assert property ($fell(program_fetch_strobe_n) |->
    $past(core_tick, 2) && fq && !dq)
    else $error("fetch strobe in wrong cycle");
  strobe_rst_a: assert property (core_reset ##1 core_reset |-> !address_latch_strobe && program_fetch_strobe_n)
    else $error("strobes active in reset");
  rst_qual_a: assert property ($rose(core_reset) |-> rp_twice)
    else $error("core reset without two high samples");
  mode_edge_a: assert property ($changed(double_speed_active) |-> $past(core_tick))
    else $error("mode changed off a halved-clock rise");
endmodule
bind dscg_top dscg_chk #(.P(4)) u_dscg_chk (.clk, .reset, .reset_pin, .fetch_external,
  .data_access, .core_tick, .periph_tick, .machine_cycle_end, .core_reset,
  .double_speed_active, .address_latch_strobe, .program_fetch_strobe_n);

// ==== verif/testbench.sv ====
/*
  Self-checking bench: APB tasks, strobe counts per machine cycle, queue model.
  Assumes the oscillator model with a period of four clk.
*/
`timescale 1ns/100ps
`include "dscg_consts.vh"
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin n_fail++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module testbench;
  logic clk, reset, rpin, fext, dacc, psel, penable, pwrite, er, ale_q, pf_q, mce_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] ac, pc, cc, al, pl, cl;
  logic [1:0] q[$];
  logic [1:0] e, r;
  wire osc, pready, pslverr, ctk, mce, crst, ale, pfs_n, dsa;
  int n_fail = 0, total_checks = 0, seed = 32'h6c406cb9;
  dscg_osc_model #(.P(4)) u_dscg_osc_model (.clk, .osc);
  dscg_top u_dscg_top (.clk, .reset, .oscillator_input(osc), .reset_pin(rpin),
    .fetch_external(fext), .data_access(dacc), .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .core_tick(ctk), .periph_tick(), .machine_cycle_end(mce),
    .core_reset(crst), .double_speed_active(dsa), .address_latch_strobe(ale),
    .program_fetch_strobe_n(pfs_n));
  initial begin clk = 0; forever #2 clk = ~clk; end
  // Strobes lag the phase by a clk, so windows start one edge after the cycle end
  always @(posedge clk) begin
    ale_q <= ale; pf_q <= pfs_n; mce_q <= mce;
    if (mce_q) begin
      al <= ac; pl <= pc; cl <= cc; ac <= ale && !ale_q; pc <= !pfs_n && pf_q; cc <= 1;
    end else begin
      ac <= ac + (ale && !ale_q); pc <= pc + (!pfs_n && pf_q); cc <= cc + 1;
    end
  end
  task test_done;
    if (n_fail == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk); psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk); penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata; er = pslverr; psel <= 0; penable <= 0;
  endtask
  task wm;
    do @(posedge clk); while (mce !== 1'b1);
  endtask
  // Inputs sampled at one cycle end steer the cycle after the next window
  task run(input logic aux, input logic sel);
    apb(1, `DSCG_AUX_ADDR, {31'h0, aux});
    apb(1, `DSCG_CKSPD_ADDR, {31'h0, sel});
    q.delete();
    for (int i = 0; i < 8; i++) begin
      wm; r = 2'($random(seed)); {fext, dacc} <= r; q.push_back(r);
      repeat (2) @(posedge clk);
      if (q.size() > 2) e = q.pop_front();
      if (i >= 3) begin
        `CHK("ale", e[0] ? 1 : (aux && !e[1]) ? 0 : 2, al)
        `CHK("fetch", (e[1] && !e[0]) ? 2 : 0, pl)
        `CHK("period", (sel ? 6 : 12) * 4, cl)
      end
    end
    apb(0, `DSCG_STAT_ADDR, 0);
    `CHK("mode", sel, rd[0])
    `CHK("mode_pin", sel, dsa)
  endtask
  initial begin
    reset = 1; rpin = 0; fext = 0; dacc = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 0; pwdata = 0;
    repeat (3) @(posedge clk);
    reset <= 0;
    apb(0, `DSCG_CKSPD_ADDR, 0);
    `CHK("speed_rst", 32'h0, rd)
    apb(0, 12'h000, 0);
    `CHK("unmapped", 1'b1, er)
    for (int m = 0; m < 4; m++) run(m[1], m[0]);
    wm; rpin <= 1; wm; rpin <= 0; wm; repeat (2) @(posedge clk);
    `CHK("short_pin", 1'b0, crst)
    rpin <= 1; wm; wm; repeat (2) @(posedge clk);
    `CHK("pin_rst", 1'b1, crst)
    apb(0, `DSCG_CKSPD_ADDR, 0);
    `CHK("sel_clr", 32'h0, rd)
    rpin <= 0; wm; repeat (2) @(posedge clk);
    `CHK("pin_rel", 1'b0, crst)
    test_done;
  end
  initial begin #40000; n_fail++; test_done; end
endmodule
